// >>> rtl/uilf_top.sv
// uart interrupt identification and line-format control with tx/rx
// assumes a classic wishbone master; registers in data bits 7:0
`timescale 1ns/1ns
`default_nettype none
module uilf_top #(
  parameter int DEPTH = uilf_pkg::FIFO_DEPTH
) (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [2:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SERIAL_IN,
  output logic             SERIAL_OUT,
  output logic             IRQ_OUT
);
  localparam int PW = $clog2(DEPTH + 1);

  logic [7:0]  interrupt_enable_reg;
  logic [7:0]  line_format_reg;
  logic [15:0] divisor;
  logic        fifo_en;
  logic [1:0]  trig_sel;
  logic [15:0] baud_cnt;
  logic        baud_tick;
  logic [2:0]  rx_sync;
  logic        rxd;
  logic [7:0]  rx_mem [DEPTH];
  logic [PW-1:0] rx_count;
  logic [$clog2(DEPTH)-1:0] rx_rd;
  logic [$clog2(DEPTH)-1:0] rx_wr;
  logic [7:0]  tx_mem [DEPTH];
  logic [PW-1:0] tx_count;
  logic [$clog2(DEPTH)-1:0] tx_rd;
  logic [$clog2(DEPTH)-1:0] tx_wr;
  logic [3:0]  err_flags;        // overrun, parity, framing, break
  logic        the_pend;
  logic [9:0]  to_ticks;
  logic [7:0]  bit_len;
  logic        to_pend;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_perr;
  logic        rx_ferr;
  logic        rx_brk;
  logic        tx_busy;
  logic        tx_load;
  logic        txd;
  logic [3:0]  next_ident;
  logic [PW-1:0] trig_lvl;
  logic        rda_pend;
  logic        req;
  logic        wr;
  logic        rd;
  logic        rd_rbr;
  logic        wr_thr;
  logic        rd_lsr;
  logic        rd_iir;
  logic        rx_push;

  assign req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr     = req && WB_WE_I && WB_SEL_I[0];
  assign rd     = req && !WB_WE_I;
  assign rd_rbr = rd && WB_ADR_I == uilf_pkg::ADDR_DATA && !line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS];
  assign wr_thr = wr && WB_ADR_I == uilf_pkg::ADDR_DATA && !line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS];
  assign rd_lsr = rd && WB_ADR_I == uilf_pkg::ADDR_LSTAT;
  assign rd_iir = rd && WB_ADR_I == uilf_pkg::ADDR_IDENT;
  assign rx_push = rx_done && (rx_count < PW'(fifo_en ? DEPTH : 1));

  // three-stage input sync; only stages two and three are looked at
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_sync <= 3'h7;
      rxd <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], SERIAL_IN};
      if (rx_sync[1] == rx_sync[2]) rxd <= rx_sync[2];
    end
  end

  // baud enable; divisor of zero stalls the link
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      baud_cnt <= 16'h0000;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (divisor != 16'h0000) begin
        if (baud_cnt >= divisor - 16'h0001) begin
          baud_cnt <= 16'h0000;
          baud_tick <= 1'b1;
        end else baud_cnt <= baud_cnt + 16'h0001;
      end
    end
  end

  // control register writes, divisor behind the access bit
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      interrupt_enable_reg <= uilf_pkg::RST_BYTE;
      line_format_reg      <= uilf_pkg::RST_BYTE;
      divisor  <= 16'h0000;
      fifo_en  <= 1'b0;
      trig_sel <= 2'b00;
    end else if (wr) begin
      unique case (WB_ADR_I)
        uilf_pkg::ADDR_DATA:
          if (line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS]) divisor[7:0] <= WB_DAT_I[7:0];
        uilf_pkg::ADDR_IEN:
          if (line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS]) divisor[15:8] <= WB_DAT_I[7:0];
          else interrupt_enable_reg <= {5'h00, WB_DAT_I[2:0]};
        uilf_pkg::ADDR_IDENT: begin
          fifo_en <= WB_DAT_I[0];
          if (WB_DAT_I[0]) trig_sel <= WB_DAT_I[7:6];
        end
        uilf_pkg::ADDR_LFMT: line_format_reg <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  // receive fifo; one entry deep outside fifo mode
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_count <= '0;
      rx_rd <= '0;
      rx_wr <= '0;
    end else if (wr && WB_ADR_I == uilf_pkg::ADDR_IDENT && WB_DAT_I[0] != fifo_en) begin
      rx_count <= '0;  // mode change empties the fifo
      rx_rd <= '0;
      rx_wr <= '0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wr] <= rx_data;
        rx_wr <= fifo_en ? rx_wr + 1'b1 : rx_wr;
      end
      if (rd_rbr && rx_count != '0) rx_rd <= fifo_en ? rx_rd + 1'b1 : rx_rd;
      rx_count <= rx_count + PW'(rx_push) - PW'(rd_rbr && rx_count != '0);
    end
  end

  // transmit fifo feeding the shifter
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_count <= '0;
      tx_rd <= '0;
      tx_wr <= '0;
    end else begin
      if (wr_thr && tx_count < PW'(fifo_en ? DEPTH : 1)) begin
        tx_mem[tx_wr] <= WB_DAT_I[7:0];
        tx_wr <= fifo_en ? tx_wr + 1'b1 : tx_wr;
      end
      if (tx_load) tx_rd <= fifo_en ? tx_rd + 1'b1 : tx_rd;
      tx_count <= tx_count + PW'(wr_thr && tx_count < PW'(fifo_en ? DEPTH : 1)) - PW'(tx_load);
    end
  end
  assign tx_load = !tx_busy && tx_count != '0;

  // line error flags; a new error in the read cycle is kept
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) err_flags <= 4'h0;
    else begin
      logic [3:0] ev;
      ev = {rx_brk, rx_ferr, rx_perr, !rx_push} & {4{rx_done}};
      err_flags <= (rd_lsr ? 4'h0 : err_flags) | ev;
    end
  end

  // tx empty pending: set on drain, cleared by holding write or ident read
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) the_pend <= 1'b0;
    else if (tx_count == '0 && !wr_thr && !(tx_count == PW'(1) && tx_load)) begin
      if (rd_iir && next_ident == uilf_pkg::ID_THE) the_pend <= 1'b0;
      else if (tx_load || !the_pend) the_pend <= the_pend | tx_load;
    end else if (wr_thr) the_pend <= 1'b0;
    else if (tx_load && tx_count == PW'(1)) the_pend <= 1'b1;
  end

  // character timeout counter in baud ticks; frame length from format
  // up to twelve bits of sixteen ticks: needs eight bits, six would wrap
  assign bit_len = 8'(16 * (7 + int'(line_format_reg[1:0]) + int'(line_format_reg[3])
                   + int'(line_format_reg[2])));
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      to_ticks <= 10'h000;
      to_pend <= 1'b0;
    end else if (!fifo_en || rx_count == '0 || rx_push || rd_rbr) begin
      to_ticks <= 10'h000;
      to_pend <= 1'b0;
    end else if (baud_tick && !to_pend) begin
      to_ticks <= to_ticks + 10'h001;
      if (to_ticks == 10'(uilf_pkg::TO_CHARS * int'(bit_len)) - 10'h001) to_pend <= 1'b1;
    end
  end

  assign trig_lvl = (trig_sel == 2'b00) ? PW'(1) : (trig_sel == 2'b01) ? PW'(4)
                  : (trig_sel == 2'b10) ? PW'(8) : PW'(14);
  assign rda_pend = fifo_en ? (rx_count >= trig_lvl) : (rx_count != '0);

  // priority encode of enabled sources, every clock
  always_comb begin
    if (interrupt_enable_reg[uilf_pkg::IEN_RLS] && err_flags != 4'h0)
      next_ident = uilf_pkg::ID_RLS;
    else if (interrupt_enable_reg[uilf_pkg::IEN_RDA] && rda_pend)
      next_ident = uilf_pkg::ID_RDA;
    else if (interrupt_enable_reg[uilf_pkg::IEN_RDA] && to_pend)
      next_ident = uilf_pkg::ID_CTO;
    else if (interrupt_enable_reg[uilf_pkg::IEN_THE] && the_pend)
      next_ident = uilf_pkg::ID_THE;
    else
      next_ident = uilf_pkg::ID_NONE;
  end

  // irq from register, high while any enabled source pends
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) IRQ_OUT <= 1'b0;
    else IRQ_OUT <= !next_ident[0];
  end

  // break forces the pin only
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) SERIAL_OUT <= 1'b1;
    else SERIAL_OUT <= txd & ~line_format_reg[uilf_pkg::LF_BRK];
  end

  // bus answer one cycle after request, unmapped reads zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      WB_DAT_O <= 32'h0000_0000;
      if (rd) begin
        unique case (WB_ADR_I)
          uilf_pkg::ADDR_DATA: WB_DAT_O[7:0] <= line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS] ?
                                 divisor[7:0] : rx_mem[rx_rd];
          uilf_pkg::ADDR_IEN: WB_DAT_O[7:0] <= line_format_reg[uilf_pkg::LF_DIVISOR_LATCH_ACCESS] ?
                                 divisor[15:8] : interrupt_enable_reg;
          uilf_pkg::ADDR_IDENT: WB_DAT_O[7:0] <= {{2{fifo_en}}, 2'b00, next_ident};
          uilf_pkg::ADDR_LFMT: WB_DAT_O[7:0] <= line_format_reg;
          uilf_pkg::ADDR_LSTAT: WB_DAT_O[7:0] <= {1'b0, !tx_busy && tx_count == '0,
                                 tx_count == '0, err_flags, rx_count != '0};
          default: ;
        endcase
      end
    end
  end

  uilf_tx u_tx (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .baud_tick (baud_tick),
    .line_fmt  (line_format_reg),
    .load      (tx_load),
    .data      (tx_mem[tx_rd]),
    .busy      (tx_busy),
    .txd       (txd)
  );

  uilf_rx u_rx (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .baud_tick (baud_tick),
    .line_fmt  (line_format_reg),
    .rxd       (rxd),
    .done      (rx_done),
    .data      (rx_data),
    .perr      (rx_perr),
    .ferr      (rx_ferr),
    .brk       (rx_brk)
  );
endmodule : uilf_top
`default_nettype wire

// >>> rtl/uilf_pkg.sv
// package for the uart interrupt and line-format block
// assumes a wishbone slave with byte-wide registers in the low lane
package uilf_pkg;
  localparam logic [2:0] ADDR_DATA    = 3'h0;  // rx buffer / tx holding / divisor low
  localparam logic [2:0] ADDR_IEN     = 3'h1;  // interrupt enable / divisor high
  localparam logic [2:0] ADDR_IDENT   = 3'h2;  // ident read / fifo control write
  localparam logic [2:0] ADDR_LFMT    = 3'h3;  // line format
  localparam logic [2:0] ADDR_LSTAT   = 3'h5;  // line status
  localparam int IEN_RDA  = 0;
  localparam int IEN_THE  = 1;
  localparam int IEN_RLS  = 2;
  localparam int LF_PEN   = 3;
  localparam int LF_EPS   = 4;
  localparam int LF_STICK = 5;
  localparam int LF_BRK   = 6;
  localparam int LF_DIVISOR_LATCH_ACCESS  = 7;
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_RLS  = 4'h6;
  localparam logic [3:0] ID_RDA  = 4'h4;
  localparam logic [3:0] ID_CTO  = 4'hC;
  localparam logic [3:0] ID_THE  = 4'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int OVS       = 16;   // baud ticks per bit
  localparam int TO_CHARS  = 4;    // idle character times for timeout
  localparam int FIFO_DEPTH = 16;
endpackage : uilf_pkg

// >>> rtl/uilf_tx.sv
// serial transmitter with programmable format
// assumes baud_tick is one clock per sixteenth bit
`timescale 1ns/1ns
`default_nettype none
module uilf_tx (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       baud_tick,
  input  wire logic [7:0] line_fmt,
  input  wire logic       load,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            txd
);
  logic [7:0] sh;
  logic [3:0] bits_left;
  logic [3:0] tick;
  logic [5:0] stop_half;
  logic [1:0] phase;      // 0 idle 1 start 2 data/par 3 stop
  logic       par_bit;
  logic       par_pend;

  // parity from current format
  function automatic logic calc_par(input logic [7:0] d, input logic [7:0] f);
    logic [7:0] m;
    m = d & (8'hFF >> (2'd3 - f[1:0]));
    if (f[uilf_pkg::LF_STICK])
      calc_par = ~f[uilf_pkg::LF_EPS];
    else
      calc_par = ^m ^ ~f[uilf_pkg::LF_EPS];
  endfunction : calc_par

  assign busy = (phase != 2'd0);

  // one stop bit, or 1.5 for 5-bit chars, or 2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'd0; sh <= 8'h00; bits_left <= 4'h0; tick <= 4'h0;
      stop_half <= 6'h00; txd <= 1'b1; par_bit <= 1'b0; par_pend <= 1'b0;
    end else if (phase == 2'd0) begin
      txd <= 1'b1;
      if (load) begin
        phase <= 2'd1; sh <= data; tick <= 4'h0;
        bits_left <= 4'(5 + int'(line_fmt[1:0]));
        par_bit <= calc_par(data, line_fmt);
        par_pend <= line_fmt[uilf_pkg::LF_PEN];
      end
    end else if (baud_tick) begin
      tick <= tick + 4'h1;
      if (phase == 2'd1) begin
        txd <= 1'b0;
        if (tick == 4'hF) phase <= 2'd2;
      end else if (phase == 2'd2) begin
        txd <= (bits_left != 4'h0) ? sh[0] : par_bit;
        if (tick == 4'hF) begin
          if (bits_left != 4'h0) begin
            sh <= sh >> 1; bits_left <= bits_left - 4'h1;
            if (bits_left == 4'h1 && !par_pend) phase <= 2'd3;
          end else phase <= 2'd3;  // parity sent
          stop_half <= !line_fmt[2] ? 6'd16 : (line_fmt[1:0] == 2'b00 ? 6'd24 : 6'd32);
        end
      end else begin
        txd <= 1'b1;
        stop_half <= stop_half - 6'h01;
        if (stop_half == 6'h01) phase <= 2'd0;
      end
    end
  end
endmodule : uilf_tx
`default_nettype wire

// >>> rtl/uilf_rx.sv
// serial receiver, checks only the first stop bit
// assumes rxd already synchronised and baud_tick at sixteen per bit
`timescale 1ns/1ns
`default_nettype none
module uilf_rx (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       baud_tick,
  input  wire logic [7:0] line_fmt,
  input  wire logic       rxd,
  output logic            done,
  output logic [7:0]      data,
  output logic            perr,
  output logic            ferr,
  output logic            brk
);
  logic [1:0] phase;
  logic [3:0] tick;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       zero_all;
  logic [3:0] nbits;
  logic [7:0] mask;
  logic       want;

  assign nbits = 4'(5 + int'(line_fmt[1:0]));
  assign mask  = 8'hFF >> (2'd3 - line_fmt[1:0]);
  assign want  = line_fmt[uilf_pkg::LF_STICK] ? ~line_fmt[uilf_pkg::LF_EPS]
               : (^(sh & mask) ^ ~line_fmt[uilf_pkg::LF_EPS]);

  // sample mid-bit; stop bits beyond the first are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'd0; tick <= 4'h0; cnt <= 4'h0; sh <= 8'h00; zero_all <= 1'b0;
      done <= 1'b0; data <= 8'h00; perr <= 1'b0; ferr <= 1'b0; brk <= 1'b0;
    end else begin
      done <= 1'b0;
      if (baud_tick) begin
        tick <= tick + 4'h1;
        unique case (phase)
          2'd0: begin
            tick <= 4'h0;
            if (!rxd) begin phase <= 2'd1; zero_all <= 1'b1; perr <= 1'b0; end
          end
          2'd1: if (tick == 4'h7) begin
            if (rxd) phase <= 2'd0;  // glitch
            else begin phase <= 2'd2; tick <= 4'h0; cnt <= 4'h0; sh <= 8'h00; end
          end
          2'd2: if (tick == 4'hF) begin
            zero_all <= zero_all & ~rxd;
            if (cnt < nbits) sh[cnt[2:0]] <= rxd;
            else perr <= (rxd != want);
            cnt <= cnt + 4'h1;
            if (cnt == nbits - 4'(!line_fmt[uilf_pkg::LF_PEN])) phase <= 2'd3;
          end
          2'd3: if (tick == 4'hF) begin
            ferr <= ~rxd;
            brk <= zero_all & ~rxd;
            data <= sh & mask;
            done <= 1'b1;
            phase <= 2'd0;
          end
        endcase
      end
    end
  end
endmodule : uilf_rx
`default_nettype wire

// >>> dv/uilf_sva.sv
// assertions for the uart interrupt and line-format block
// assumes a classic wishbone master and the port list of uilf_top
`timescale 1ns/1ns
`default_nettype none
module uilf_chk #(
  parameter int DEPTH = 16
) (
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [2:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SERIAL_IN,
  input wire logic        SERIAL_OUT,
  input wire logic        IRQ_OUT
);
  logic [7:0] lf_sh;
  logic [2:0] ien_sh;
  logic       fifo_sh;
  logic       take;
  logic       rd_id;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  assign take  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd_id = WB_ACK_O && !WB_WE_I && WB_ADR_I == uilf_pkg::ADDR_IDENT;
  // shadows of format and enables; enables hide behind the divisor when bit 7 is set
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lf_sh  <= 8'h00;
      ien_sh <= 3'h0;
      fifo_sh <= 1'b0;
    end else if (take && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I == uilf_pkg::ADDR_IDENT) fifo_sh <= WB_DAT_I[0];
      if (WB_ADR_I == uilf_pkg::ADDR_LFMT) lf_sh <= WB_DAT_I[7:0];
      if (WB_ADR_I == uilf_pkg::ADDR_IEN && !lf_sh[7]) ien_sh <= WB_DAT_I[2:0];
    end
  end
  a_ack_after_take: assert property (take |=> WB_ACK_O) else $error("no ack after request");
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_format_readback: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I == uilf_pkg::ADDR_LFMT
    |-> WB_DAT_O[7:0] == lf_sh) else $error("format read differs");
  a_enable_upper_zero: assert property (WB_ACK_O && !WB_WE_I && !lf_sh[7]
    && WB_ADR_I == uilf_pkg::ADDR_IEN |-> WB_DAT_O[7:3] == 5'h00) else $error("enable bits 7:3");
  a_break_low: assert property (lf_sh[6] && $past(lf_sh[6], 3) |-> !SERIAL_OUT)
    else $error("break not low");
  a_irq_masked: assert property (ien_sh == 3'h0 && $past(ien_sh, 3) == 3'h0 |-> !IRQ_OUT)
    else $error("irq while masked");
  a_ident_bits_45: assert property (rd_id |-> WB_DAT_O[5:4] == 2'h0) else $error("ident 5:4");
  a_ident_bits_67: assert property (rd_id |-> WB_DAT_O[7:6] == {2{fifo_sh}})
    else $error("ident 7:6");
  a_ident_timeout_fifo: assert property (rd_id && !fifo_sh |-> !WB_DAT_O[3])
    else $error("ident bit 3 outside fifo mode");
  a_read_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data above byte lane");
  a_ident_source_enabled: assert property (rd_id |->
    (WB_DAT_O[3:0] == uilf_pkg::ID_NONE) || (WB_DAT_O[3:0] == uilf_pkg::ID_RLS && ien_sh[2])
    || (WB_DAT_O[3:0] == uilf_pkg::ID_THE && ien_sh[1]) || (ien_sh[0]
    && (WB_DAT_O[3:0] == uilf_pkg::ID_RDA || WB_DAT_O[3:0] == uilf_pkg::ID_CTO)))
    else $error("ident code illegal or disabled");
  c_line_status: cover property (rd_id && WB_DAT_O[3:0] == uilf_pkg::ID_RLS);
  c_tx_empty: cover property (rd_id && WB_DAT_O[3:0] == uilf_pkg::ID_THE);
  c_irq_rise: cover property ($rose(IRQ_OUT));
  c_timeout: cover property (rd_id && WB_DAT_O[3:0] == uilf_pkg::ID_CTO);
endmodule : uilf_chk
bind uilf_top uilf_chk #(.DEPTH(DEPTH)) i_chk (.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SERIAL_IN(SERIAL_IN),
  .SERIAL_OUT(SERIAL_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// >>> dv/uilf_far.sv
// remote serial device model facing the block's serial pins
// assumes a fixed bit time in clocks set by the bench's divisor
`timescale 1ns/1ns
`default_nettype none
module uilf_far #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;  // idle mark level
  // frame out: start, data lsb first, one stop of chosen level; a low stop forces an error
  task automatic send(input logic [7:0] d, input int nb, input logic stop);
    @(posedge clk);
    line_out <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    line_out <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : send
  // frame in: sample mid-bit; bounded wait for the start edge
  task automatic recv(input int nb, input bit par, output logic [7:0] d, output logic p,
                      output logic s);
    int n;
    d = 8'h00;
    p = 1'b0;
    n = 0;
    while (line_in !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) begin
      s = 1'bx;  // no start edge seen; the stop check in t_format then fails
      return;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = line_in;
    end
    if (par) begin
      repeat (BIT_CLKS) @(posedge clk);
      p = line_in;
    end
    repeat (BIT_CLKS) @(posedge clk);
    s = line_in;
  endtask : recv
endmodule : uilf_far
`default_nettype wire

// >>> dv/uart_irq_and_line_format_test.sv
// self-checking bench for the uart interrupt and line-format block
// assumes divisor 1, so one serial bit lasts sixteen clocks
`timescale 1ns/1ns
`default_nettype none
module uart_irq_and_line_format_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [2:0]  adr = 3'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack;
  logic        ser_in;
  logic        ser_out;
  logic        irq;
  int          mismatches = 0;
  int          cmp_count = 0;
  always #20 clk = ~clk;
  uilf_top #(.DEPTH(16)) i_dut (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out), .IRQ_OUT(irq));
  uilf_far #(.BIT_CLKS(16)) i_far (.clk(clk), .line_in(ser_out), .line_out(ser_in));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic cycle: request held until ack is sampled, then released
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_i <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      check("bus ack", 8'h00, 8'h01);
      end_of_test;
    end else begin
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, q, exp);
  endtask : rd
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("irq level", {7'h00, irq}, {7'h00, lvl});
    if (irq !== lvl) end_of_test;
  endtask : wait_irq
  // reset values, read-back, unused bits and divisor mapping
  task automatic t_regs;
    rd("enable", uilf_pkg::ADDR_IEN, 8'h00);
    rd("format", uilf_pkg::ADDR_LFMT, 8'h00);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    rd("unmapped", 3'h4, 8'h00);
    wr(uilf_pkg::ADDR_LFMT, 8'h5B);
    rd("format", uilf_pkg::ADDR_LFMT, 8'h5B);
    wr(uilf_pkg::ADDR_LFMT, 8'h03);
    wr(uilf_pkg::ADDR_IEN, 8'hFD);
    rd("enable", uilf_pkg::ADDR_IEN, 8'h05);
    wr(uilf_pkg::ADDR_LFMT, 8'h83);
    wr(uilf_pkg::ADDR_DATA, 8'h01);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    wr(uilf_pkg::ADDR_LFMT, 8'h03);
    rd("enable", uilf_pkg::ADDR_IEN, 8'h05);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    $display("test regs done");
  endtask : t_regs
  // lengths and parity kinds on the wire
  task automatic t_format;
    logic [7:0] lf[3] = '{8'h1C, 8'h0B, 8'h2A};
    logic [7:0] dv[3] = '{8'h13, 8'hA7, 8'h35};
    logic [7:0] pe[3] = '{8'h01, 8'h00, 8'h01};
    int         nb[3] = '{5, 8, 7};
    logic [7:0] d;
    logic       p;
    logic       s;
    for (int i = 0; i < 3; i++) begin
      wr(uilf_pkg::ADDR_LFMT, lf[i]);
      fork
        i_far.recv(nb[i], 1'b1, d, p, s);
        wr(uilf_pkg::ADDR_DATA, dv[i]);
      join
      check("tx data", d, dv[i]);
      check("tx parity", {7'h00, p}, pe[i]);
      check("tx stop", {7'h00, s}, 8'h01);
    end
    wr(uilf_pkg::ADDR_LFMT, 8'h03);
    $display("test format done");
  endtask : t_format
  // holding-empty source cleared by reading the ident
  task automatic t_tx_empty;
    logic [7:0] d;
    logic       p;
    logic       s;
    wr(uilf_pkg::ADDR_IEN, 8'h02);
    fork
      i_far.recv(8, 1'b0, d, p, s);
      wr(uilf_pkg::ADDR_DATA, 8'hC3);
    join
    check("tx data", d, 8'hC3);
    wait_irq(1'b1);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h02);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    wait_irq(1'b0);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    $display("test tx empty done");
  endtask : t_tx_empty
  // receive data, masking, and line status outranking data
  task automatic t_rx;
    wr(uilf_pkg::ADDR_IEN, 8'h05);
    i_far.send(8'h5A, 8, 1'b1);
    wait_irq(1'b1);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h04);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    wait_irq(1'b0);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    wr(uilf_pkg::ADDR_IEN, 8'h05);
    rd("rx data", uilf_pkg::ADDR_DATA, 8'h5A);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    i_far.send(8'h3C, 8, 1'b0);
    wait_irq(1'b1);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h06);
    rd("status", uilf_pkg::ADDR_LSTAT, 8'h69);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h04);
    rd("rx data", uilf_pkg::ADDR_DATA, 8'h3C);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    $display("test rx done");
  endtask : t_rx
  // break level and fifo mode flags
  task automatic t_misc;
    wr(uilf_pkg::ADDR_LFMT, 8'h43);
    repeat (3) @(posedge clk);
    check("serial out", {7'h00, ser_out}, 8'h00);
    wr(uilf_pkg::ADDR_LFMT, 8'h03);
    repeat (3) @(posedge clk);
    check("serial out", {7'h00, ser_out}, 8'h01);
    wr(uilf_pkg::ADDR_IDENT, 8'h01);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'hC1);
    wr(uilf_pkg::ADDR_IDENT, 8'h00);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'h01);
    $display("test misc done");
  endtask : t_misc
  // fifo mode: one char below trigger four, then the idle timeout
  task automatic t_timeout;
    wr(uilf_pkg::ADDR_IDENT, 8'h41);
    wr(uilf_pkg::ADDR_IEN, 8'h01);
    i_far.send(8'h96, 8, 1'b1);
    repeat (560) @(posedge clk);
    check("irq early", {7'h00, irq}, 8'h00);
    wait_irq(1'b1);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'hCC);
    rd("rx data", uilf_pkg::ADDR_DATA, 8'h96);
    rd("ident", uilf_pkg::ADDR_IDENT, 8'hC1);
    wr(uilf_pkg::ADDR_IDENT, 8'h00);
    wr(uilf_pkg::ADDR_IEN, 8'h00);
    $display("test timeout done");
  endtask : t_timeout
  // reset for four cycles, then the scenarios in turn
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_format;
    t_tx_empty;
    t_rx;
    t_misc;
    t_timeout;
    end_of_test;
  end
endmodule : uart_irq_and_line_format_test
`default_nettype wire
